//--- core/dbt_bank_decode.v
// dram bank decode and strobe timing configuration with ahb-lite register slave
//
// How it works
// RULE1 - non-edo page precharge 0.5 or 1.5 clocks
// RULE2 - edo page precharge 1.0 or 2.0 clocks
// RULE3 - refresh column strobe leads 1.0/2.0 clocks
// RULE4 - software writes timing before alternate transfers
// RULE5 - compare base bits 31-17 per bank
// RULE6 - base and mask survive both resets
// RULE7 - alternate master hidden address bits read zero
// RULE8 - mask bit one makes base bit don't-care
// RULE9 - core transfer types blocked by mask bits
// RULE10 - alternate master ignores transfer type masks
// RULE11 - port size selects data byte lanes
// RULE12 - page size code 512, 1k, 2k
// RULE13 - page mode normal, burst or fast
// RULE14 - write enable gates strobes on writes
// RULE15 - read enable gates strobes on reads
// RULE16 - both resets clear bank control registers
// RULE17 - edo matters only in page modes
// RULE18 - hit needs match, allowed type, direction
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dbt_consts.vh"

module dbt_bank_decode #(
  parameter NUM_BANKS = 2
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        normal_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        xfer_req,
  input  wire [31:0] xfer_addr,
  input  wire        xfer_write,
  input  wire        xfer_alt,
  input  wire        xfer_super,
  input  wire        xfer_code,
  input  wire [3:0]  ext_addr_pin_en,
  output reg         dec_valid_q,
  output reg         dec_hit_q,
  output reg         dec_bank_q,
  output reg  [3:0]  dec_lanes_q,
  output reg  [1:0]  dec_port_width_sel_q,
  output reg  [1:0]  dec_page_style_q,
  output reg  [3:0]  dec_page_bits_q,
  output reg         dec_edo_active_q,
  output reg  [2:0]  dec_cas_pre_half_q,
  output reg  [2:0]  refresh_cas_lead_half_q
);

  // ---------------------------------------------------------------- bus slave
  // zero wait state: every register read or write completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // writes are posted: the address is caught in the address phase and hwdata
  // one edge later, so a read taken right behind a write still sees the old
  // contents

  wire                  bus_take = hsel & htrans[1] & hready;
  reg                   wr_pend_q;
  reg [`DBT_ADDR_W-1:0] wr_addr_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`DBT_ADDR_W{1'b0}};
    end else begin
      wr_pend_q <= bus_take & hwrite;
      if (bus_take & hwrite) begin
        wr_addr_q <= haddr[`DBT_ADDR_W-1:0];
      end
    end
  end

  // hsize is not checked: only word transfers are expected on this window
  wire wr_timing = wr_pend_q & (wr_addr_q == `DBT_OFS_TIMING);

  // ---------------------------------------------------------------- timing config
  reg tm_edo_q;
  reg tm_cp_q;
  reg tm_csr_q;

  // software is expected to load this before any alternate master transfer;
  // nothing here blocks a write during one, the decode simply picks up the
  // new bits on the next request
  // master reset clears it, the normal reset leaves it alone
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {tm_edo_q, tm_cp_q, tm_csr_q} <= `DBT_TM_RESET;
    end else if (wr_timing) begin
      // RULE4
      tm_edo_q <= hwdata[`DBT_TM_EDO];
      tm_cp_q  <= hwdata[`DBT_TM_CP];
      tm_csr_q <= hwdata[`DBT_TM_CSR];
    end
  end

  // ---------------------------------------------------------------- per bank
  // the compare word is transfer address bits 31..17, msb first; a bank is
  // reachable by an alternate master only if its base bits above the wired-out
  // pins are zero or masked
  wire [`DBT_CMP_W-1:0] cmp_addr;
  wire [3:0]            hid_top;

  // alternate masters only see the pins that are wired out as address lines
  assign hid_top  = xfer_alt ? (xfer_addr[27:24] & ext_addr_pin_en) : xfer_addr[27:24]; // RULE7
  assign cmp_addr = {(xfer_alt ? 4'h0 : xfer_addr[31:28]), hid_top,
                     xfer_addr[23:`DBT_CMP_LO]}; // RULE7

  wire [NUM_BANKS-1:0]              bk_match;
  wire [NUM_BANKS-1:0]              bk_type_ok;
  wire [NUM_BANKS-1:0]              bk_dir_ok;
  wire [NUM_BANKS-1:0]              bk_hit;
  wire [NUM_BANKS*`DBT_CMP_W-1:0]   bk_base;
  wire [NUM_BANKS*`DBT_CMP_W-1:0]   bk_bam;
  wire [NUM_BANKS*4-1:0]            bk_tmask;
  wire [NUM_BANKS*`DBT_CTRL_W-1:0]  bk_ctrl;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_bank
      // offsets worked out as integers, then cut to the window width
      localparam integer           OFS_BASE_I = `DBT_OFS_BASE0 + gi * `DBT_BANK_STRIDE;
      localparam integer           OFS_MASK_I = `DBT_OFS_MASK0 + gi * `DBT_BANK_STRIDE;
      localparam integer           OFS_CTRL_I = `DBT_OFS_CTRL0 + gi * `DBT_CTRL_STRIDE;
      localparam [`DBT_ADDR_W-1:0] OFS_BASE   = OFS_BASE_I[`DBT_ADDR_W-1:0];
      localparam [`DBT_ADDR_W-1:0] OFS_MASK   = OFS_MASK_I[`DBT_ADDR_W-1:0];
      localparam [`DBT_ADDR_W-1:0] OFS_CTRL   = OFS_CTRL_I[`DBT_ADDR_W-1:0];

      reg [`DBT_CMP_W-1:0]  base_q;
      reg [`DBT_CMP_W-1:0]  bam_q;
      reg [3:0]             tmask_q;
      reg [`DBT_CTRL_W-1:0] ctrl_q;
      reg                   type_blk;

      // no reset at all: contents must survive master and normal reset
      always @(posedge sys_clk) begin
        if (wr_pend_q && wr_addr_q == OFS_BASE) begin
          base_q <= hwdata[`DBT_BASE_LO +: `DBT_CMP_W]; // RULE6
        end
        if (wr_pend_q && wr_addr_q == OFS_MASK) begin
          bam_q   <= hwdata[`DBT_BAM_LO +: `DBT_CMP_W]; // RULE6
          tmask_q <= {hwdata[`DBT_SC], hwdata[`DBT_SD], hwdata[`DBT_UC], hwdata[`DBT_UD]};
        end
      end

      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          ctrl_q <= `DBT_CTRL_RESET; // RULE16
        end else if (normal_rst) begin
          ctrl_q <= `DBT_CTRL_RESET; // RULE16
        end else if (wr_pend_q && wr_addr_q == OFS_CTRL) begin
          ctrl_q <= hwdata[`DBT_CTRL_W-1:0];
        end
      end

      // tmask_q order: {sc, sd, uc, ud}
      always @* begin
        case ({xfer_super, xfer_code})
          2'h3:    type_blk = tmask_q[3]; // RULE9
          2'h2:    type_blk = tmask_q[2]; // RULE9
          2'h1:    type_blk = tmask_q[1]; // RULE9
          default: type_blk = tmask_q[0]; // RULE9
        endcase
      end

      assign bk_match[gi]   = ~|((cmp_addr ^ base_q) & ~bam_q); // RULE5 RULE8
      assign bk_type_ok[gi] = xfer_alt | ~type_blk; // RULE10
      assign bk_dir_ok[gi]  = xfer_write ? ctrl_q[`DBT_WR] : ctrl_q[`DBT_RD]; // RULE14 RULE15
      assign bk_hit[gi]     = bk_match[gi] & bk_type_ok[gi] & bk_dir_ok[gi]; // RULE18

      assign bk_base[gi*`DBT_CMP_W +: `DBT_CMP_W]   = base_q;
      assign bk_bam[gi*`DBT_CMP_W +: `DBT_CMP_W]    = bam_q;
      assign bk_tmask[gi*4 +: 4]                    = tmask_q;
      assign bk_ctrl[gi*`DBT_CTRL_W +: `DBT_CTRL_W] = ctrl_q;
    end
  endgenerate

  // ---------------------------------------------------------------- bank select
  // the lowest numbered bank that fully hits wins; overlapping banks are a setup error
  // a bank that matches but is disabled for this direction does not hide
  // another bank behind it
  reg                   sel_hit;
  reg                   sel_bank;
  reg [`DBT_CTRL_W-1:0] sel_ctrl;
  integer               bi;

  always @* begin
    sel_hit  = 1'b0;
    sel_bank = 1'b0;
    sel_ctrl = `DBT_CTRL_RESET;
    for (bi = NUM_BANKS - 1; bi >= 0; bi = bi - 1) begin
      if (bk_hit[bi]) begin
        sel_hit  = 1'b1;
        sel_bank = bi[0];
        sel_ctrl = bk_ctrl[bi*`DBT_CTRL_W +: `DBT_CTRL_W];
      end
    end
  end

  wire [1:0] sel_ps  = sel_ctrl[`DBT_PS_HI:`DBT_PS_LO];
  wire [1:0] sel_bps = sel_ctrl[`DBT_BPS_HI:`DBT_BPS_LO];
  wire [1:0] sel_pm  = sel_ctrl[`DBT_PM_HI:`DBT_PM_LO];

  reg [3:0] lanes_d;
  reg [3:0] page_bits_d;
  reg [1:0] style_d;
  reg       page_mode_d;
  reg       edo_active_d;
  reg [2:0] pre_half_d;

  // 10 and 11 both mean a 16-bit port on the upper lanes
  // a reserved page size gives no page bits, but page mode and edo timing still follow the mode code
  // edo timing only matters once a page is kept open
  always @* begin
    case (sel_ps)
      `DBT_PS_32: lanes_d = `DBT_LANES_32; // RULE11
      `DBT_PS_8:  lanes_d = `DBT_LANES_8;  // RULE11
      default:    lanes_d = `DBT_LANES_16; // RULE11
    endcase
    case (sel_bps)
      `DBT_BPS_512: page_bits_d = `DBT_PAGE_BITS_512; // RULE12
      `DBT_BPS_1K:  page_bits_d = `DBT_PAGE_BITS_1K;  // RULE12
      `DBT_BPS_2K:  page_bits_d = `DBT_PAGE_BITS_2K;  // RULE12
      default:      page_bits_d = `DBT_PAGE_BITS_NONE;
    endcase
    // the reserved mode code falls back to single accesses
    case (sel_pm)
      `DBT_PM_BURST: style_d = `DBT_PM_BURST;  // RULE13
      `DBT_PM_FAST:  style_d = `DBT_PM_FAST;   // RULE13
      default:       style_d = `DBT_PM_NORMAL; // RULE13
    endcase
    page_mode_d  = (style_d == `DBT_PM_BURST) | (style_d == `DBT_PM_FAST);
    edo_active_d = tm_edo_q & page_mode_d; // RULE17
    if (edo_active_d) begin
      pre_half_d = tm_cp_q ? `DBT_PRE_EDO_1 : `DBT_PRE_EDO_0; // RULE2
    end else begin
      pre_half_d = tm_cp_q ? `DBT_PRE_STD_1 : `DBT_PRE_STD_0; // RULE1
    end
  end

  // ---------------------------------------------------------------- decode output
  // a blocked or missed transfer leaves every strobe-related field at zero;
  // port size and page style fall back to the reset control codes there, as no bank is selected
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid_q          <= 1'b0;
      dec_hit_q            <= 1'b0;
      dec_bank_q           <= 1'b0;
      dec_lanes_q          <= 4'h0;
      dec_port_width_sel_q <= 2'h0;
      dec_page_style_q     <= 2'h0;
      dec_page_bits_q      <= 4'h0;
      dec_edo_active_q     <= 1'b0;
      dec_cas_pre_half_q   <= 3'h0;
    end else begin
      dec_valid_q <= xfer_req;
      if (xfer_req) begin
        dec_hit_q            <= sel_hit; // RULE14 RULE15 RULE18
        dec_bank_q           <= sel_bank;
        dec_lanes_q          <= sel_hit ? lanes_d : 4'h0;
        dec_port_width_sel_q <= sel_ps;
        dec_page_style_q     <= style_d;
        dec_page_bits_q      <= page_mode_d ? page_bits_d : `DBT_PAGE_BITS_NONE;
        dec_edo_active_q     <= edo_active_d;
        dec_cas_pre_half_q   <= page_mode_d ? pre_half_d : 3'h0; // RULE1 RULE2
      end
    end
  end

  // refresh only ever uses column-before-row, so the lead is global
  // it takes effect one edge after the timing write lands
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_cas_lead_half_q <= `DBT_LEAD_0;
    end else begin
      refresh_cas_lead_half_q <= tm_csr_q ? `DBT_LEAD_1 : `DBT_LEAD_0; // RULE3
    end
  end

  // ---------------------------------------------------------------- status
  // last decode: [1:0] address match, [3:2] type allowed, [5:4] direction on,
  // [6] hit, [7] bank, [8] alternate master
  // debug view only; the layout assumes exactly two banks
  reg [8:0] status_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= 9'h000;
    end else if (xfer_req) begin
      status_q <= {xfer_alt, sel_bank, sel_hit, bk_dir_ok[1:0], bk_type_ok[1:0],
                   bk_match[1:0]};
    end
  end

  // ---------------------------------------------------------------- read mux
  // read data is registered in the address phase so it stands through the data phase
  // reserved bits read as zero; unmapped offsets read all zero
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[`DBT_ADDR_W-1:0])
      `DBT_OFS_BASE0:  rd_d[`DBT_BASE_LO +: `DBT_CMP_W] = bk_base[0 +: `DBT_CMP_W];
      `DBT_OFS_BASE1:  rd_d[`DBT_BASE_LO +: `DBT_CMP_W] = bk_base[`DBT_CMP_W +: `DBT_CMP_W];
      `DBT_OFS_MASK0: begin
        rd_d[`DBT_BAM_LO +: `DBT_CMP_W]                         = bk_bam[0 +: `DBT_CMP_W];
        {rd_d[`DBT_SC], rd_d[`DBT_SD], rd_d[`DBT_UC], rd_d[`DBT_UD]} = bk_tmask[3:0];
      end
      `DBT_OFS_MASK1: begin
        rd_d[`DBT_BAM_LO +: `DBT_CMP_W]                         = bk_bam[`DBT_CMP_W +: `DBT_CMP_W];
        {rd_d[`DBT_SC], rd_d[`DBT_SD], rd_d[`DBT_UC], rd_d[`DBT_UD]} = bk_tmask[7:4];
      end
      `DBT_OFS_TIMING: begin
        rd_d[`DBT_TM_EDO] = tm_edo_q;
        rd_d[`DBT_TM_CP]  = tm_cp_q;
        rd_d[`DBT_TM_CSR] = tm_csr_q;
      end
      `DBT_OFS_CTRL0:  rd_d[`DBT_CTRL_W-1:0] = bk_ctrl[0 +: `DBT_CTRL_W];
      `DBT_OFS_CTRL1:  rd_d[`DBT_CTRL_W-1:0] = bk_ctrl[`DBT_CTRL_W +: `DBT_CTRL_W];
      `DBT_OFS_STATUS: rd_d[8:0] = status_q;
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take & ~hwrite) begin
      // only a read address phase moves it, so it stands for the whole
      // data phase whatever the master drives there
      hrdata <= rd_d;
    end
  end

endmodule // dbt_bank_decode

//--- core/dbt_consts.vh
// register map, field positions, codes and timing counts for the dram bank decode block
`ifndef DBT_CONSTS_VH
`define DBT_CONSTS_VH

// register byte offsets inside the block window (haddr[7:0])
`define DBT_ADDR_W         8
`define DBT_OFS_BASE0      8'h4c
`define DBT_OFS_MASK0      8'h50
`define DBT_OFS_BASE1      8'h58
`define DBT_OFS_MASK1      8'h5c
`define DBT_OFS_TIMING     8'h60
`define DBT_OFS_CTRL0      8'h64
`define DBT_OFS_CTRL1      8'h68
`define DBT_OFS_STATUS     8'h6c
`define DBT_BANK_STRIDE    8'h0c
`define DBT_CTRL_STRIDE    8'h04

// strobe_timing_config fields
`define DBT_TM_EDO         14
`define DBT_TM_CP          1
`define DBT_TM_CSR         0
`define DBT_TM_RESET       3'h0

// bank_base_reg / bank_mask_reg fields (transfer address bits 31..17)
`define DBT_CMP_W          15
`define DBT_CMP_LO         17
`define DBT_BASE_LO        1
`define DBT_BAM_LO         17
`define DBT_SC             4
`define DBT_SD             3
`define DBT_UC             2
`define DBT_UD             1

// bank_control_reg fields
`define DBT_CTRL_W         8
`define DBT_CTRL_RESET     8'h00
`define DBT_PS_HI          7
`define DBT_PS_LO          6
`define DBT_BPS_HI         5
`define DBT_BPS_LO         4
`define DBT_PM_HI          3
`define DBT_PM_LO          2
`define DBT_WR             1
`define DBT_RD             0

// codes
`define DBT_PS_32          2'h0
`define DBT_PS_8           2'h1
`define DBT_PM_NORMAL      2'h0
`define DBT_PM_BURST       2'h1
`define DBT_PM_FAST        2'h3
`define DBT_BPS_512        2'h0
`define DBT_BPS_1K         2'h1
`define DBT_BPS_2K         2'h2
`define DBT_LANES_32       4'hf
`define DBT_LANES_8        4'h8
`define DBT_LANES_16       4'hc
`define DBT_PAGE_BITS_512  4'h9
`define DBT_PAGE_BITS_1K   4'ha
`define DBT_PAGE_BITS_2K   4'hb
`define DBT_PAGE_BITS_NONE 4'h0

// strobe times in half system clocks
`define DBT_PRE_STD_0      3'h1
`define DBT_PRE_STD_1      3'h3
`define DBT_PRE_EDO_0      3'h2
`define DBT_PRE_EDO_1      3'h4
`define DBT_LEAD_0         3'h2
`define DBT_LEAD_1         3'h4

`endif

//--- testbench/dbt_bank_decode_properties.sv
// decode output relations checker for the dram bank decode block
`timescale 1ns/1ps
module dbt_bank_decode_properties #(
  parameter NUM_BANKS = 2
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       xfer_req,
  input wire logic       dec_valid_q,
  input wire logic       dec_hit_q,
  input wire logic [3:0] dec_lanes_q,
  input wire logic [1:0] dec_port_width_sel_q,
  input wire logic [1:0] dec_page_style_q,
  input wire logic [3:0] dec_page_bits_q,
  input wire logic       dec_edo_active_q,
  input wire logic [2:0] dec_cas_pre_half_q,
  input wire logic [2:0] refresh_cas_lead_half_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence lone_req_s; xfer_req ##1 !xfer_req; endsequence
  sequence one_pulse_s; dec_valid_q ##1 !dec_valid_q; endsequence
  valid_pulse_a: assert property (lone_req_s |-> one_pulse_s)
    else $error("valid pulse missing");
  valid_idle_a: assert property (!xfer_req |=> !dec_valid_q)
    else $error("valid without request");
  result_hold_a: assert property (!xfer_req |=> $stable(dec_hit_q) && $stable(dec_lanes_q))
    else $error("decode result moved");
  lane_map_a: assert property (dec_valid_q && dec_hit_q |-> dec_lanes_q ==
    (dec_port_width_sel_q == 2'h0 ? 4'hf : dec_port_width_sel_q == 2'h1 ? 4'h8 : 4'hc))
    else $error("lanes wrong for port size");
  miss_lanes_a: assert property (dec_valid_q && !dec_hit_q |-> dec_lanes_q == 4'h0)
    else $error("lanes on miss");
  normal_mode_a: assert property (dec_valid_q && dec_page_style_q == 2'h0 |->
    !dec_edo_active_q && dec_cas_pre_half_q == 3'h0 && dec_page_bits_q == 4'h0)
    else $error("page timing in normal mode");
  pre_time_a: assert property (dec_valid_q && dec_page_style_q != 2'h0 |->
    (dec_edo_active_q ? (dec_cas_pre_half_q inside {3'h2, 3'h4})
                      : (dec_cas_pre_half_q inside {3'h1, 3'h3})))
    else $error("precharge time wrong");
  style_code_a: assert property (dec_page_style_q != 2'h2)
    else $error("reserved page mode reported");
  refresh_lead_a: assert property (refresh_cas_lead_half_q inside {3'h2, 3'h4})
    else $error("refresh lead wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule // dbt_bank_decode_properties

//--- testbench/dbt_bank_decode_tb.sv
// self-checking bench for the dram bank decode block
`timescale 1ns/1ps
`include "dbt_consts.vh"
module dbt_bank_decode_tb;
  logic        sys_clk = 0, rst_b = 0, normal_rst = 0, hsel = 0, hwrite = 0;
  logic        xfer_req = 0, xfer_write = 0, xfer_alt = 0, xfer_super = 0, xfer_code = 0;
  logic [31:0] haddr = 0, hwdata = 0, xfer_addr = 0, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  ext_addr_pin_en = 0;
  wire         hreadyout, hresp, dec_valid_q, dec_hit_q, dec_bank_q, extended_data_out_en;
  wire [31:0]  hrdata;
  wire [3:0]   lanes, bits;
  wire [1:0]   pw, style;
  wire [2:0]   pre, lead;
  int          err_total = 0, check_count = 0, cyc = 0, exp0 = 0, exp1 = 0, a0, a1;

  dbt_bank_decode #(.NUM_BANKS(2)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .normal_rst(normal_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .xfer_req(xfer_req), .xfer_addr(xfer_addr),
    .xfer_write(xfer_write), .xfer_alt(xfer_alt), .xfer_super(xfer_super),
    .xfer_code(xfer_code), .ext_addr_pin_en(ext_addr_pin_en), .dec_valid_q(dec_valid_q),
    .dec_hit_q(dec_hit_q), .dec_bank_q(dec_bank_q), .dec_lanes_q(lanes),
    .dec_port_width_sel_q(pw), .dec_page_style_q(style), .dec_page_bits_q(bits),
    .dec_edo_active_q(extended_data_out_en), .dec_cas_pre_half_q(pre), .refresh_cas_lead_half_q(lead));
  dbt_dram_model mem_u (.sys_clk(sys_clk), .dec_valid_q(dec_valid_q), .dec_hit_q(dec_hit_q),
    .dec_bank_q(dec_bank_q), .dec_lanes_q(lanes), .act0_cnt(a0), .act1_cnt(a1));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // entered just after an edge; no wait count assumed, the cycle ceiling cuts a hang
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task xf(input logic [31:0] a, input logic w, al, su, co, eh, eb);
    xfer_req <= 1;
    xfer_addr <= a;
    xfer_write <= w;
    xfer_alt <= al;
    xfer_super <= su;
    xfer_code <= co;
    @(posedge sys_clk);
    xfer_req <= 0;
    #1;
    chk("valid", 1, dec_valid_q);
    chk("hit", eh, dec_hit_q);
    if (eh) begin
      chk("bank", eb, dec_bank_q);
      if (eb) exp1++;
      else exp0++;
    end
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    rchk("ctrl0", `DBT_OFS_CTRL0, 0);
    rchk("ctrl1", `DBT_OFS_CTRL1, 0);
    bus(1, `DBT_OFS_TIMING, 0);
    bus(1, `DBT_OFS_BASE0, 32'h10);
    bus(1, `DBT_OFS_MASK0, 32'he_0000);
    bus(1, `DBT_OFS_CTRL0, 32'h0f);
    bus(1, 8'h70, 32'hffff_ffff);
    rchk("base0", `DBT_OFS_BASE0, 32'h10);
    rchk("mask0", `DBT_OFS_MASK0, 32'he_0000);
    rchk("unmapped", 8'h70, 0);
    $display("register test done");
    xf(32'h001e_0000, 0, 0, 1, 0, 1, 0);
    xf(32'h0020_0000, 0, 0, 1, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      bus(1, `DBT_OFS_MASK0, 32'he_0000 | (32'h10 >> i));
      xf(32'h0010_0000, 0, 0, i < 2, ~i[0], 0, 0);
      xf(32'h0010_0000, 0, 0, i >= 2, i[0], 1, 0);
      xf(32'h0010_0000, 0, 1, i < 2, ~i[0], 1, 0);
    end
    bus(1, `DBT_OFS_MASK0, 32'he_0000);
    bus(1, `DBT_OFS_CTRL0, 32'h0e);
    xf(32'h0010_0000, 0, 0, 0, 0, 0, 0);
    xf(32'h0010_0000, 1, 0, 0, 0, 1, 0);
    bus(1, `DBT_OFS_CTRL0, 32'h0d);
    xf(32'h0010_0000, 0, 0, 0, 0, 1, 0);
    xf(32'h0010_0000, 1, 0, 0, 0, 0, 0);
    $display("type and enable test done");
    for (int k = 0; k < 4; k++) begin
      bus(1, `DBT_OFS_CTRL0, {k[1:0], (k == 3) ? 2'h2 : k[1:0], k[1:0], 2'h3});
      xf(32'h0010_0000, 0, 0, 0, 0, 1, 0);
      chk("pw", k[1:0], pw);
      chk("lanes", k == 0 ? 4'hf : k == 1 ? 4'h8 : 4'hc, lanes);
      chk("style", k == 2 ? 2'h0 : k[1:0], style);
      chk("page", k[0] ? (k == 1 ? 4'ha : 4'hb) : 4'h0, bits);
    end
    bus(1, `DBT_OFS_CTRL0, 32'h0f);
    for (int t = 0; t < 4; t++) begin
      bus(1, `DBT_OFS_TIMING, {t[1], 12'h0, t[0], t[0]});
      xf(32'h0010_0000, 0, 0, 0, 0, 1, 0);
      chk("pre", t[1] ? (t[0] ? 3'h4 : 3'h2) : (t[0] ? 3'h3 : 3'h1), pre);
      chk("lead", t[0] ? 3'h4 : 3'h2, lead);
      chk("page512", 4'h9, bits);
    end
    bus(1, `DBT_OFS_CTRL0, 32'h03);
    xf(32'h0010_0000, 0, 0, 0, 0, 1, 0);
    chk("edo", 0, extended_data_out_en);
    chk("pre0", 0, pre);
    $display("timing test done");
    bus(1, `DBT_OFS_BASE1, 32'h100);
    bus(1, `DBT_OFS_MASK1, 0);
    bus(1, `DBT_OFS_CTRL1, 32'h03);
    xf(32'h1100_0000, 0, 1, 0, 0, 0, 0);
    ext_addr_pin_en <= 4'h1;
    xf(32'h1100_0000, 0, 1, 0, 0, 1, 1);
    xf(32'h1100_0000, 0, 0, 0, 0, 0, 0);
    $display("alternate master test done");
    normal_rst <= 1;
    @(posedge sys_clk);
    normal_rst <= 0;
    @(posedge sys_clk);
    rchk("ctrl0", `DBT_OFS_CTRL0, 0);
    rchk("ctrl1", `DBT_OFS_CTRL1, 0);
    rchk("base1", `DBT_OFS_BASE1, 32'h100);
    rchk("timing", `DBT_OFS_TIMING, 32'h4003);
    bus(1, `DBT_OFS_CTRL1, 32'h03);
    rst_b <= 0;
    @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    rchk("mask0", `DBT_OFS_MASK0, 32'he_0000);
    rchk("ctrl1", `DBT_OFS_CTRL1, 0);
    rchk("timing", `DBT_OFS_TIMING, 0);
    xf(32'h0100_0000, 0, 0, 0, 0, 0, 0);
    chk("act0", exp0, a0);
    chk("act1", exp1, a1);
    rchk("status", `DBT_OFS_STATUS, 32'h0000_000e);
    $display("reset test done");
    close_out();
  end
endmodule // dbt_bank_decode_tb

bind dbt_bank_decode dbt_bank_decode_properties #(.NUM_BANKS(NUM_BANKS)) prop_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
  .xfer_req(xfer_req), .dec_valid_q(dec_valid_q), .dec_hit_q(dec_hit_q),
  .dec_lanes_q(dec_lanes_q), .dec_port_width_sel_q(dec_port_width_sel_q),
  .dec_page_style_q(dec_page_style_q), .dec_page_bits_q(dec_page_bits_q),
  .dec_edo_active_q(dec_edo_active_q), .dec_cas_pre_half_q(dec_cas_pre_half_q),
  .refresh_cas_lead_half_q(refresh_cas_lead_half_q));

//--- testbench/dbt_dram_model.sv
// behavioural dram bank pair that counts strobe activations per decoded hit
`timescale 1ns/1ps
module dbt_dram_model (
  input wire logic       sys_clk,
  input wire logic       dec_valid_q,
  input wire logic       dec_hit_q,
  input wire logic       dec_bank_q,
  input wire logic [3:0] dec_lanes_q,
  output int             act0_cnt,
  output int             act1_cnt
);
  initial begin
    act0_cnt = 0;
    act1_cnt = 0;
  end
  // a bank only sees strobes on a hit with at least one lane enabled
  always @(posedge sys_clk) begin
    if (dec_valid_q === 1'b1 && dec_hit_q === 1'b1 && dec_lanes_q !== 4'h0) begin
      if (dec_bank_q) act1_cnt <= act1_cnt + 1;
      else act0_cnt <= act0_cnt + 1;
    end
  end
endmodule // dbt_dram_model
